/* rtl/fpp_pkg.sv */
// constants shared by the frame buffer pixel packer
// assumes a 32-bit classic wishbone register bus and byte addressing
package fpp_pkg;
	// register byte offsets
	localparam logic [7:0] REG_CFG = 8'h00;
	localparam logic [7:0] REG_GEOM = 8'h04;
	localparam logic [7:0] REG_COORD = 8'h08;
	localparam logic [7:0] REG_ADDR = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_STRIDE = 8'h14;
	// cfg field positions
	localparam int CFG_DEPTH_LSB = 0;
	localparam int CFG_PACK_BIT = 4;
	localparam int CFG_SCAN_BIT = 5;
	// geom and coord field positions
	localparam int LO_LSB = 0;
	localparam int HI_LSB = 16;
	// status field positions
	localparam int ST_BIT_LSB = 0;
	localparam int ST_DEPTH_LSB = 8;
	localparam int ST_DONE_BIT = 16;
	localparam int ST_PEND_BIT = 17;
	// reset values
	localparam logic [2:0] CFG_DEPTH_RST = 3'h3;
	localparam logic CFG_PACK_RST = 1'b0;
	localparam logic CFG_SCAN_RST = 1'b0;
	localparam logic [15:0] GEOM_W_RST = 16'h0000;
	localparam logic [15:0] GEOM_H_RST = 16'h0000;
	// pixel depth codes
	typedef enum logic [2:0] {
		DEPTH_1 = 3'h0,
		DEPTH_2 = 3'h1,
		DEPTH_4 = 3'h2,
		DEPTH_8 = 3'h3,
		DEPTH_16 = 3'h4,
		DEPTH_24 = 3'h5,
		DEPTH_32 = 3'h6
	} fpp_depth_t;
	// order encodings for byte_packing_order and buffer_scan_order
	localparam logic ORDER_LINE = 1'b0;
	localparam logic ORDER_COLUMN = 1'b1;
endpackage

/* rtl/fpp_packer.sv */
// frame buffer pixel packer: pixel coordinate to byte address and bit position
// assumes a classic wishbone master and a same-clock requester on the pixel port
`timescale 1ns/100ps
`default_nettype none
module fpp_packer (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// pixel request port
	input wire logic req_in,
	input wire logic [15:0] x_in,
	input wire logic [15:0] y_in,
	// pixel answer port
	output logic valid_out,
	output logic [31:0] addr_out,
	output logic [4:0] bit_out
);

	////////////////////////////////////////////////////////////////////////////
	// decode helpers

	// bits per pixel for a depth code; reserved code acts as 8
	function automatic logic [5:0] depth_bits(input logic [2:0] code);
		case (code)
			fpp_pkg::DEPTH_1: depth_bits = 6'h01;
			fpp_pkg::DEPTH_2: depth_bits = 6'h02;
			fpp_pkg::DEPTH_4: depth_bits = 6'h04;
			fpp_pkg::DEPTH_16: depth_bits = 6'h10;
			fpp_pkg::DEPTH_24: depth_bits = 6'h18;
			fpp_pkg::DEPTH_32: depth_bits = 6'h20;
			default: depth_bits = 6'h08;
		endcase
	endfunction

	// byte lane merge for writable registers
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// configuration and software state

	logic [2:0] depth;
	logic pack_col;
	logic scan_col;
	logic [15:0] width;
	logic [15:0] height;
	logic [15:0] sw_x;
	logic [15:0] sw_y;
	logic sw_pend;
	logic sw_done;
	logic [31:0] sw_addr;
	logic [4:0] sw_bit;
	logic [31:0] stride;
	logic bus_req;
	logic bus_wr;
	logic take_port;
	logic take_sw;
	logic [31:0] cfg_word;
	logic [31:0] geom_word;
	logic [31:0] coord_word;
	logic [31:0] cfg_merged;

	assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	assign bus_wr = bus_req & wb_we_in;
	// the pixel port wins; a software request waits until req_in is low
	assign take_port = req_in;
	assign take_sw = sw_pend & ~req_in;
	assign cfg_word = {26'h0, scan_col, pack_col, 1'b0, depth};
	// merged once so the field slices come from a plain net
	assign cfg_merged = merge(cfg_word, wb_dat_in, wb_sel_in);
	assign geom_word = {height, width};
	assign coord_word = {sw_y, sw_x};

	// configuration registers, set by the integrator before use
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			depth <= fpp_pkg::CFG_DEPTH_RST;
			pack_col <= fpp_pkg::CFG_PACK_RST;
			scan_col <= fpp_pkg::CFG_SCAN_RST;
		end else if (bus_wr && wb_adr_in == fpp_pkg::REG_CFG) begin
			{scan_col, pack_col} <= cfg_merged[fpp_pkg::CFG_SCAN_BIT -: 2];
			depth <= cfg_merged[fpp_pkg::CFG_DEPTH_LSB +: 3];
		end
	end

	// display geometry
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			width <= fpp_pkg::GEOM_W_RST;
			height <= fpp_pkg::GEOM_H_RST;
		end else if (bus_wr && wb_adr_in == fpp_pkg::REG_GEOM) begin
			{height, width} <= merge(geom_word, wb_dat_in, wb_sel_in);
		end
	end

	// software coordinate; a write queues one conversion
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sw_x <= 16'h0000;
			sw_y <= 16'h0000;
			sw_pend <= 1'b0;
		end else begin
			if (bus_wr && wb_adr_in == fpp_pkg::REG_COORD) begin
				{sw_y, sw_x} <= merge(coord_word, wb_dat_in, wb_sel_in);
				sw_pend <= 1'b1; // new request beats the slot that takes the old one
			end else if (take_sw) begin
				sw_pend <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// stride of one padded line or column, rebuilt every cycle from config

	logic [5:0] bits;
	logic sub_byte;
	logic [1:0] lg;
	logic [2:0] mask;
	logic [31:0] next_stride;

	assign bits = depth_bits(depth);
	assign sub_byte = bits < 6'h08;
	assign lg = (bits == 6'h04) ? 2'h2 : (bits == 6'h02) ? 2'h1 : 2'h0;
	assign mask = 3'h7 >> lg; // pixels per byte minus one

	// ceil(count * depth / 8) when both orders match, else the count; width times pixel bytes for full bytes
	always_comb begin
		next_stride = 32'h00000000;
		if (!sub_byte) begin
			next_stride = width * 32'(bits[5:3]);
		end else if (scan_col == fpp_pkg::ORDER_LINE) begin
			if (pack_col == fpp_pkg::ORDER_LINE) begin
				next_stride = 32'((17'(width) + 17'(mask)) >> (3 - lg));
			end else begin
				next_stride = 32'(width);
			end
		end else begin
			if (pack_col == fpp_pkg::ORDER_LINE) begin
				next_stride = 32'(height);
			end else begin
				next_stride = 32'((17'(height) + 17'(mask)) >> (3 - lg));
			end
		end
	end

	// stride register also read back by software
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			stride <= 32'h00000000;
		end else begin
			stride <= next_stride;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// stage one: split the coordinate into major step, minor offset and bit

	logic [15:0] cx;
	logic [15:0] cy;
	logic [15:0] next_major;
	logic [31:0] next_minor;
	logic [2:0] next_idx;
	logic [15:0] s1_major;
	logic [31:0] s1_minor;
	logic [4:0] s1_bit;
	logic s1_valid;
	logic s1_port;

	assign cx = take_port ? x_in : sw_x;
	assign cy = take_port ? y_in : sw_y;

	// for sub-byte depths the split depends on the buffer order and the packing order
	always_comb begin
		next_major = cy;
		next_minor = 32'(cx) * 32'(bits[5:3]);
		next_idx = 3'h0;
		if (sub_byte) begin
			if (scan_col == fpp_pkg::ORDER_LINE && pack_col == fpp_pkg::ORDER_LINE) begin
				next_major = cy;
				next_minor = 32'(cx >> (3 - lg));
				next_idx = cx[2:0] & mask;
			end else if (scan_col == fpp_pkg::ORDER_LINE) begin
				next_major = cy >> (3 - lg);
				next_minor = 32'(cx);
				next_idx = cy[2:0] & mask;
			end else if (pack_col == fpp_pkg::ORDER_LINE) begin
				next_major = cx >> (3 - lg);
				next_minor = 32'(cy);
				next_idx = cx[2:0] & mask;
			end else begin
				next_major = cx;
				next_minor = 32'(cy >> (3 - lg));
				next_idx = cy[2:0] & mask;
			end
		end
	end

	// stage one registers; pixel 0 lands in the low bits of its byte
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s1_valid <= 1'b0;
			s1_port <= 1'b0;
			s1_major <= 16'h0000;
			s1_minor <= 32'h00000000;
			s1_bit <= 5'h00;
		end else begin
			s1_valid <= take_port | take_sw;
			s1_port <= take_port;
			s1_major <= next_major;
			s1_minor <= next_minor;
			s1_bit <= 5'(next_idx) << lg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// stage two: address = major * stride + minor; split to ease 4 ns timing

	logic [31:0] next_addr;

	assign next_addr = 32'(48'(s1_major) * 48'(stride)) + s1_minor;

	// pixel port answer
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			valid_out <= 1'b0;
			addr_out <= 32'h00000000;
			bit_out <= 5'h00;
		end else begin
			valid_out <= s1_valid & s1_port;
			if (s1_valid && s1_port) begin
				addr_out <= next_addr;
				bit_out <= s1_bit;
			end
		end
	end

	// software answer; done clears on a new coordinate write
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sw_addr <= 32'h00000000;
			sw_bit <= 5'h00;
			sw_done <= 1'b0;
		end else begin
			if (s1_valid && !s1_port) begin
				sw_addr <= next_addr;
				sw_bit <= s1_bit;
				sw_done <= 1'b1; // set wins over clear
			end else if (bus_wr && wb_adr_in == fpp_pkg::REG_COORD) begin
				sw_done <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// wishbone answer: ack one cycle after the request, unmapped reads zero

	logic [31:0] next_rd;

	always_comb begin
		next_rd = 32'h00000000;
		case (wb_adr_in)
			fpp_pkg::REG_CFG: next_rd = cfg_word;
			fpp_pkg::REG_GEOM: next_rd = geom_word;
			fpp_pkg::REG_COORD: next_rd = coord_word;
			fpp_pkg::REG_ADDR: next_rd = sw_addr;
			fpp_pkg::REG_STATUS: begin
				next_rd[fpp_pkg::ST_BIT_LSB +: 5] = sw_bit;
				next_rd[fpp_pkg::ST_DEPTH_LSB +: 6] = bits;
				next_rd[fpp_pkg::ST_DONE_BIT] = sw_done;
				next_rd[fpp_pkg::ST_PEND_BIT] = sw_pend;
			end
			fpp_pkg::REG_STRIDE: next_rd = stride;
			default: next_rd = 32'h00000000;
		endcase
	end

	// ack and read data from flops
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h00000000;
		end else begin
			wb_ack_out <= bus_req;
			wb_dat_out <= bus_req ? next_rd : 32'h00000000;
		end
	end

endmodule
`default_nettype wire

/* sim/fpp_packer_checker.sv */
// assertions on the packer bus and pixel ports
// assumes a bind into every packer instance
`timescale 1ns/100ps
`default_nettype none
module fpp_checker (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// wishbone
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic wb_ack_out,
	// pixel port
	input wire logic req_in,
	input wire logic [15:0] x_in,
	input wire logic [15:0] y_in,
	input wire logic valid_out,
	input wire logic [31:0] addr_out,
	input wire logic [4:0] bit_out
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);
	// request then answer two edges on
	sequence req_s;
		req_in;
	endsequence
	sequence ans_s;
		##2 valid_out;
	endsequence
	ack_resp_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("ack missing");
	ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack too long");
	ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in) && $past(wb_stb_in))
		else $error("ack without request");
	dat_idle_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
		else $error("read data outside ack");
	valid_lat_a: assert property (req_s |-> ans_s)
		else $error("answer late");
	valid_cause_a: assert property (valid_out |-> $past(req_in, 2))
		else $error("answer without request");
	addr_hold_a: assert property (!valid_out |-> $stable(addr_out) && $stable(bit_out))
		else $error("answer changed");
	bit_range_a: assert property (valid_out |-> bit_out < 5'h8)
		else $error("bit outside byte");
endmodule
bind fpp_packer fpp_checker i_fpp_checker (.clock_in(clock_in), .rst_n_in(rst_n_in),
	.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
	.wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
	.wb_ack_out(wb_ack_out), .req_in(req_in), .x_in(x_in), .y_in(y_in),
	.valid_out(valid_out), .addr_out(addr_out), .bit_out(bit_out));
`default_nettype wire

/* sim/fpp_requester.sv */
// display side requester model on the pixel port
// assumes answers return in request order
`timescale 1ns/100ps
`default_nettype none
module fpp_requester (
	// clock
	input wire logic clock_in,
	// answers
	input wire logic valid_in,
	input wire logic [31:0] addr_in,
	input wire logic [4:0] bit_in,
	// requests
	output logic req_out,
	output logic [15:0] x_out,
	output logic [15:0] y_out
);
	logic [31:0] qa [$];
	logic [31:0] qb [$];
	initial begin
		req_out = 1'b0;
		x_out = 16'h0;
		y_out = 16'h0;
	end
	// two back to back requests; idle coords inverted so none are trusted
	task issue2(input logic [15:0] x0, y0, x1, y1);
		@(posedge clock_in);
		req_out <= 1'b1;
		x_out <= x0;
		y_out <= y0;
		@(posedge clock_in);
		x_out <= x1;
		y_out <= y1;
		@(posedge clock_in);
		req_out <= 1'b0;
		x_out <= ~x1;
		y_out <= ~y1;
	endtask
	// capture answers in order
	always @(posedge clock_in) begin
		if (valid_in === 1'b1) begin
			qa.push_back(addr_in);
			qb.push_back({27'h0, bit_in});
		end
	end
endmodule
`default_nettype wire

/* sim/fpp_packer_test.sv */
// self-checking bench for the pixel packer
// assumes the requester model and the bound checker
`timescale 1ns/100ps
`default_nettype none
module fpp_packer_test;
	logic clock_in, rst_n_in, cyc, stb, we, ack, valid;
	logic [7:0] adr;
	logic [31:0] wd, rd, addr, q;
	logic [15:0] x, y;
	logic [4:0] bitp;
	logic req;
	logic [3:0] sel;
	logic [3:0] lanes;
	int n_errors = 0;
	int total_checks = 0;
	localparam int W = 20;
	localparam int H = 11;
	int bpp [8] = '{1, 2, 4, 8, 16, 24, 32, 8};
	fpp_packer i_fpp_packer (.clock_in(clock_in), .rst_n_in(rst_n_in), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wd),
		.wb_dat_out(rd), .wb_ack_out(ack), .req_in(req), .x_in(x), .y_in(y),
		.valid_out(valid), .addr_out(addr), .bit_out(bitp));
	fpp_requester i_fpp_requester (.clock_in(clock_in), .valid_in(valid), .addr_in(addr),
		.bit_in(bitp), .req_out(req), .x_out(x), .y_out(y));
	initial begin
		clock_in = 1'b0;
		forever #2 clock_in = ~clock_in;
	end
	////////////////////////////////////////
	task results;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t saw %h want %h", $time, seen, exp);
		end
	endtask
	// one classic cycle, held until ack is sampled
	// no local limit: a missing ack is caught by the watchdog
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= lanes;
		wd <= d;
		do begin
			@(posedge clock_in);
		end while (ack !== 1'b1);
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// expected byte address; m bit 0 packing, bit 1 scan
	function automatic logic [31:0] ea(int b, int m, int px, int py);
		int p;
		p = 8 / b;
		if (b >= 8)
			return 32'((py * W + px) * (b / 8));
		case (m)
			0: return 32'(py * ((W * b + 7) / 8) + px / p);
			1: return 32'((py / p) * W + px);
			2: return 32'((px / p) * H + py);
			default: return 32'(px * ((H * b + 7) / 8) + py / p);
		endcase
	endfunction
	function automatic logic [31:0] eb(int b, int m, int px, int py);
		if (b >= 8)
			return 32'h0;
		return 32'((((m % 2) ? py : px) % (8 / b)) * b);
	endfunction
	////////////////////////////////////////
	task t_reset;
		bus(1'b0, fpp_pkg::REG_CFG, 32'h0);
		chk(q, 32'h3);
		bus(1'b0, fpp_pkg::REG_GEOM, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, fpp_pkg::REG_ADDR, 32'hFFFF);
		bus(1'b0, fpp_pkg::REG_ADDR, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		// partial byte lanes: only the width half may change
		lanes = 4'h3;
		bus(1'b1, fpp_pkg::REG_GEOM, 32'h00070005);
		lanes = 4'hF;
		bus(1'b0, fpp_pkg::REG_GEOM, 32'h0);
		chk(q, 32'h00000005);
	endtask
	// every order pair for sub-byte depths, line order only for the rest; padded edges hit at x 19 and y 10
	task t_modes;
		int b;
		bus(1'b1, fpp_pkg::REG_GEOM, {16'(H), 16'(W)});
		for (int c = 0; c < 8; c++) begin
			for (int m = 0; m < 4; m++) begin
				b = bpp[c];
				if (c < 3 || m == 0) begin
					bus(1'b1, fpp_pkg::REG_CFG, 32'(c) | 32'(m << 4));
					if (c < 3 && m % 3 == 0) begin
						bus(1'b0, fpp_pkg::REG_STRIDE, 32'h0);
						chk(q, 32'((((m > 0) ? H : W) * b + 7) / 8));
					end
					i_fpp_requester.issue2(16'd13, 16'd5, 16'd19, 16'd10);
					repeat (4) @(posedge clock_in);
					chk(i_fpp_requester.qa.pop_front(), ea(b, m, 13, 5));
					chk(i_fpp_requester.qb.pop_front(), eb(b, m, 13, 5));
					chk(i_fpp_requester.qa.pop_front(), ea(b, m, 19, 10));
					chk(i_fpp_requester.qb.pop_front(), eb(b, m, 19, 10));
				end
			end
		end
	endtask
	// software conversion through the coordinate register
	task t_sw;
		int n;
		bus(1'b1, fpp_pkg::REG_CFG, 32'h1);
		bus(1'b1, fpp_pkg::REG_COORD, {16'd5, 16'd13});
		n = 0;
		do begin
			bus(1'b0, fpp_pkg::REG_STATUS, 32'h0);
			n++;
		end while (q[16] !== 1'b1 && n < 20);
		chk(32'(q[16]), 32'h1);
		chk(32'(q[13:8]), 32'h2);
		chk(32'(q[4:0]), eb(2, 0, 13, 5));
		bus(1'b0, fpp_pkg::REG_ADDR, 32'h0);
		chk(q, ea(2, 0, 13, 5));
	endtask
	initial begin
		rst_n_in = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h0;
		wd = 32'h0;
		sel = 4'hF;
		lanes = 4'hF;
		repeat (12) @(posedge clock_in);
		rst_n_in <= 1'b1;
		t_reset;
		t_modes;
		t_sw;
		results;
	end
	// watchdog: the run needs a few hundred cycles, this allows 5000
	initial begin
		#20000;
		n_errors++;
		results;
	end
endmodule
`default_nettype wire
